/* hdl/comparator_debounce_ctrl.sv */
// Comparator, converter and amplifier control with debounce and AHB-Lite registers.
//
// Behaviour
// - Converter enable bit seven switches converter.
// - Six-bit code drives converter output.
// - Unimplemented bits read zero, ignore writes.
// - Amplifier enable bit six, resets one.
// - Gain field selects sixteen gains, resets 1111.
// - Status bit seven shows comparator output.
// - Two-bit hysteresis field, resets 00.
// - Comparator enable bit zero, resets one.
// - Negative input: pin two, pin one, converter.
// - Positive input: amplifier, pin one, pin two.
// - Debounce field: none, 4 to 128 ticks.
// - Every rising comparator edge raises event.
// - Edge held past debounce time raises event.
// - Edge failing debounce raises no event.
// - Pull-high dropped while pin selected.
// - Events set edge and debounced flags.
//
// Bus timing.
// The slave never stretches a transfer: hreadyout is tied high.
// An address phase is taken at the rising edge where hsel,
// hready and htrans[1] are all high.
// Read data is picked in the address phase and registered.
// It stands for exactly the data phase and is zero otherwise.
// Write data is taken from hwdata at the end of the data phase.
// A read right after a write to the same register sees the old
// value, because the read mux looks at the address phase.
// Software should leave one idle cycle before a readback.
//
// Comparator path.
// The raw level is sampled once, gated by the enable bit.
// A rising edge is seen in the same cycle the sample goes high.
// The edge event pulses one cycle after that.
// The edge flag is set at the same edge as the pulse.
//
// Debounce timing.
// The low-speed tick is a one-cycle pulse every lirc_div cycles.
// Its phase runs free, so a qualified edge waits N to N+1 ticks.
// The count restarts on each edge and is dropped on a fall.
// With a select of zero the rising edge qualifies at once.
//
// Interrupt.
// Each event sets a sticky status bit; a status read clears it.
// An event in the cycle of the clearing read stays set.
// The irq output follows the masked status at the same edge, with no lag.
//
// The analog circuits themselves sit outside this block.
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
module comparator_debounce_ctrl #(
   parameter int lirc_div = cmp_debounce_pkg::lirc_div_default
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        comparator_raw,
   output logic             converter_enable,
   output logic      [5:0]  converter_code,
   output logic      [1:0]  converter_clock_select,
   output logic             amplifier_enable,
   output logic      [3:0]  amplifier_gain_select,
   output logic      [1:0]  hysteresis_select,
   output logic             comparator_enable,
   output logic      [1:0]  negative_input_select,
   output logic      [1:0]  positive_input_select,
   output logic             pin_one_pullup_disable,
   output logic             pin_two_pullup_disable,
   output logic             comparator_edge_event,
   output logic             debounced_edge_event,
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Helper functions.

   // Debounce length in low-speed ticks for a time select code.
   function automatic logic [7:0] debounce_ticks(input logic [2:0] sel);
      logic [7:0] t;
      t = 8'h00;
      if (sel == 3'h0) begin
         t = 8'h00;
      end else if (sel >= 3'h6) begin
         t = 8'h80;
      end else begin
         t = 8'h02 << sel;
      end
      return t;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register storage.

   logic [7:0] conv_reg;         // Converter code control.
   logic [7:0] amp_reg;          // Amplifier control.
   logic [7:0] gain_reg;         // Amplifier gain.
   logic [7:0] comparator_control_reg;         // Comparator control, writable part.
   logic [7:0] mux_reg;          // Comparator input select.
   logic [7:0] deb_reg;          // Debounce control.
   logic [7:0] status_reg;       // Sticky interrupt flags.
   logic [7:0] mask_reg;         // Interrupt mask.
   logic       dphase_reg;       // A data phase is pending.
   logic       dwrite_reg;       // Pending phase is a write.
   logic [7:0] daddr_reg;        // Pending phase address.
   logic       comp_reg;         // Sampled comparator output.
   logic       comp_prev_reg;    // Comparator output one cycle earlier.
   logic [$clog2(lirc_div+1)-1:0] div_reg; // Low-speed tick divider.
   logic       tick_reg;         // One-cycle low-speed tick.
   logic       deb_busy_reg;     // Debounce count in progress.
   logic [7:0] deb_cnt_reg;      // Elapsed low-speed ticks.
   logic       edge_ev_reg;      // Registered edge event.
   logic       deb_ev_reg;       // Registered debounced event.
   logic       irq_reg;          // Registered interrupt.
   logic [31:0] rdata_reg;       // Registered read data.
   logic       pull_one_reg;     // Pin one pull-high disconnect.
   logic       pull_two_reg;     // Pin two pull-high disconnect.

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode.

   // Address phase is accepted when selected, the bus is ready and htrans[1] is high.
   wire        addr_take = hsel & hready & htrans[1];
   wire        wr_en     = dphase_reg & dwrite_reg;
   wire        rd_take   = addr_take & ~hwrite;
   wire [7:0]  wsel_data = hwdata[7:0];
   wire        wr_conv   = wr_en && (daddr_reg == cmp_debounce_pkg::converter_code_control_off);
   wire        wr_amp    = wr_en && (daddr_reg == cmp_debounce_pkg::amplifier_control_off);
   wire        wr_gain   = wr_en && (daddr_reg == cmp_debounce_pkg::amplifier_gain_off);
   wire        wr_comparator_control   = wr_en && (daddr_reg == cmp_debounce_pkg::comparator_control_off);
   wire        wr_mux    = wr_en && (daddr_reg == cmp_debounce_pkg::comparator_input_select_off);
   wire        wr_deb    = wr_en && (daddr_reg == cmp_debounce_pkg::debounce_control_off);
   wire        wr_mask   = wr_en && (daddr_reg == cmp_debounce_pkg::irq_mask_off);
   wire        rd_status = rd_take && (haddr[7:0] == cmp_debounce_pkg::irq_status_off);

   // Input select after this cycle's write, so the pull-high
   // controls change in the same cycle as the select outputs.
   wire [7:0]  mux_next  = wr_mux ?
      (wsel_data & cmp_debounce_pkg::comparator_input_select_mask) : mux_reg;

   // Comparator control reads with the live output in bit seven.
   wire [7:0]  comparator_control_view = {comp_reg, comparator_control_reg[6:0]};

   // Read mux selected from the address phase; unmapped addresses read zero.
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      if (haddr[7:0] == cmp_debounce_pkg::converter_code_control_off) begin
         rd_mux = conv_reg;
      end else if (haddr[7:0] == cmp_debounce_pkg::amplifier_control_off) begin
         rd_mux = amp_reg;
      end else if (haddr[7:0] == cmp_debounce_pkg::amplifier_gain_off) begin
         rd_mux = gain_reg;
      end else if (haddr[7:0] == cmp_debounce_pkg::comparator_control_off) begin
         rd_mux = comparator_control_view;
      end else if (haddr[7:0] == cmp_debounce_pkg::comparator_input_select_off) begin
         rd_mux = mux_reg;
      end else if (haddr[7:0] == cmp_debounce_pkg::debounce_control_off) begin
         rd_mux = deb_reg;
      end else if (haddr[7:0] == cmp_debounce_pkg::irq_status_off) begin
         rd_mux = status_reg;
      end else if (haddr[7:0] == cmp_debounce_pkg::irq_mask_off) begin
         rd_mux = mask_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Debounce and event logic.

   wire        rise      = comp_reg & ~comp_prev_reg;
   wire [7:0]  deb_len   = debounce_ticks(deb_reg[2:0]);
   // Qualified once the output has stayed high beyond the selected count.
   wire        deb_done  = deb_busy_reg & comp_reg & tick_reg & (deb_cnt_reg >= deb_len);
   // With no debounce the rising edge itself qualifies.
   wire        deb_now   = rise & (deb_len == 8'h00);
   wire        deb_event = deb_done | deb_now;
   wire [7:0]  ev_bits   = {6'h00, deb_event, rise};
   wire [7:0]  clr_bits  = rd_status ? 8'hff : 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Processes.

   // Bus data phase tracking; the slave always answers in zero wait states.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dphase_reg <= 1'b0;
         dwrite_reg <= 1'b0;
         daddr_reg  <= 8'h00;
         rdata_reg  <= 32'h0000_0000;
      end else begin
         dphase_reg <= addr_take;
         dwrite_reg <= hwrite;
         daddr_reg  <= haddr[7:0];
         rdata_reg  <= rd_take ? {24'h000000, rd_mux} : 32'h0000_0000;
      end
   end

   // Control registers; writes keep only implemented bits.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         conv_reg <= cmp_debounce_pkg::converter_code_control_rst;
         amp_reg  <= cmp_debounce_pkg::amplifier_control_rst;
         gain_reg <= cmp_debounce_pkg::amplifier_gain_rst;
         comparator_control_reg <= cmp_debounce_pkg::comparator_control_rst;
         mux_reg  <= cmp_debounce_pkg::comparator_input_select_rst;
         deb_reg  <= cmp_debounce_pkg::debounce_control_rst;
         mask_reg <= cmp_debounce_pkg::irq_mask_rst;
      end else begin
         if (wr_conv) conv_reg <= wsel_data & cmp_debounce_pkg::converter_code_control_mask;
         if (wr_amp)  amp_reg  <= wsel_data & cmp_debounce_pkg::amplifier_control_mask;
         if (wr_gain) gain_reg <= wsel_data & cmp_debounce_pkg::amplifier_gain_mask;
         if (wr_comparator_control) comparator_control_reg <= wsel_data & cmp_debounce_pkg::comparator_control_mask;
         if (wr_mux)  mux_reg  <= wsel_data & cmp_debounce_pkg::comparator_input_select_mask;
         if (wr_deb)  deb_reg  <= wsel_data & cmp_debounce_pkg::debounce_control_mask;
         if (wr_mask) mask_reg <= wsel_data & cmp_debounce_pkg::irq_mask_mask;
      end
   end

   // Comparator sampling and low-speed tick divider.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         comp_reg      <= 1'b0;
         comp_prev_reg <= 1'b0;
         div_reg       <= '0;
         tick_reg      <= 1'b0;
      end else begin
         comp_reg      <= comparator_raw & comparator_control_reg[cmp_debounce_pkg::comparator_enable_bit];
         comp_prev_reg <= comp_reg;
         tick_reg      <= (div_reg == $bits(div_reg)'(lirc_div - 1));
         div_reg       <= (div_reg == $bits(div_reg)'(lirc_div - 1)) ? '0 : div_reg + 1'b1;
      end
   end

   // Debounce counter.
   // A new edge always wins, so a bounce restarts the count.
   // A fall while counting drops the count without an event.
   // Qualifying also ends the count, so one edge gives one event.
   // The count only moves on low-speed ticks.
   // Hazard: changing the time select mid-count takes effect at
   // once, against the new length.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         deb_busy_reg <= 1'b0;
         deb_cnt_reg  <= 8'h00;
      end else if (rise && deb_len != 8'h00) begin
         deb_busy_reg <= 1'b1;
         deb_cnt_reg  <= 8'h00;
      end else if (!comp_reg || deb_done) begin
         deb_busy_reg <= 1'b0;
         deb_cnt_reg  <= 8'h00;
      end else if (deb_busy_reg && tick_reg) begin
         deb_cnt_reg  <= deb_cnt_reg + 8'h01;
      end
   end

   // pull-high disconnect
   // A pin loses its pull-high while either select field picks it.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         // Both selects reset to 00; the negative one then picks pin two.
         pull_one_reg <= 1'b0;
         pull_two_reg <= 1'b1;
      end else begin
         pull_one_reg <= (mux_next[5:4] == 2'h1) | (mux_next[1:0] == 2'h1);
         pull_two_reg <= (mux_next[5:4] == 2'h0) | mux_next[1];
      end
   end

   // Sticky flags: set wins over clear-on-read; registered events and interrupt.
   // The whole status word clears on a read of its address.
   // The interrupt uses the next status value, so it lags the
   // flag by nothing and the event by one cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_reg  <= 8'h00;
         edge_ev_reg <= 1'b0;
         deb_ev_reg  <= 1'b0;
         irq_reg     <= 1'b0;
      end else begin
         status_reg  <= (status_reg & ~clr_bits) | ev_bits;
         edge_ev_reg <= rise;
         deb_ev_reg  <= deb_event;
         irq_reg     <= |(((status_reg & ~clr_bits) | ev_bits) & mask_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from registers or tied constants.

   assign hrdata    = rdata_reg;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   assign converter_enable       = conv_reg[cmp_debounce_pkg::converter_enable_bit];

   assign converter_code         = conv_reg[5:0];

   // clock select passed on
   // Only 00 is meaningful; other codes are passed on unchecked.
   assign converter_clock_select = amp_reg[1:0];

   assign amplifier_enable       = amp_reg[cmp_debounce_pkg::amplifier_enable_bit];

   assign amplifier_gain_select  = gain_reg[3:0];

   assign hysteresis_select      = comparator_control_reg[5:4];

   assign comparator_enable      = comparator_control_reg[cmp_debounce_pkg::comparator_enable_bit];

   assign negative_input_select  = mux_reg[5:4];

   assign positive_input_select  = mux_reg[1:0];

   // pull-high disconnect from its own flip-flops
   assign pin_one_pullup_disable = pull_one_reg;
   assign pin_two_pullup_disable = pull_two_reg;

   // Event pulses and interrupt.
   assign comparator_edge_event  = edge_ev_reg;
   assign debounced_edge_event   = deb_ev_reg;
   assign irq                    = irq_reg;

endmodule

/* hdl/cmp_debounce_pkg.sv */
// Package with register map, field positions, reset values and timing constants.
package cmp_debounce_pkg;
   // Register byte offsets on the AHB-Lite bus.
   localparam logic [7:0] converter_code_control_off  = 8'h00;
   localparam logic [7:0] amplifier_control_off       = 8'h04;
   localparam logic [7:0] amplifier_gain_off          = 8'h08;
   localparam logic [7:0] comparator_control_off      = 8'h0c;
   localparam logic [7:0] comparator_input_select_off = 8'h10;
   localparam logic [7:0] debounce_control_off        = 8'h14;
   localparam logic [7:0] irq_status_off              = 8'h18;
   localparam logic [7:0] irq_mask_off                = 8'h1c;

   // Field positions.
   localparam int converter_enable_bit  = 7;
   localparam int amplifier_enable_bit  = 6;
   localparam int comp_output_bit       = 7;
   localparam int comparator_enable_bit = 0;
   localparam int edge_flag_bit         = 0;
   localparam int debounced_flag_bit    = 1;

   // Writable bit masks of each register.
   localparam logic [7:0] converter_code_control_mask  = 8'hbf;
   localparam logic [7:0] amplifier_control_mask       = 8'h43;
   localparam logic [7:0] amplifier_gain_mask          = 8'h0f;
   localparam logic [7:0] comparator_control_mask      = 8'h31;
   localparam logic [7:0] comparator_input_select_mask = 8'h33;
   localparam logic [7:0] debounce_control_mask        = 8'h07;
   localparam logic [7:0] irq_mask_mask                = 8'h03;

   // Values after reset.
   localparam logic [7:0] converter_code_control_rst  = 8'h00;
   localparam logic [7:0] amplifier_control_rst       = 8'h40;
   localparam logic [7:0] amplifier_gain_rst          = 8'h0f;
   localparam logic [7:0] comparator_control_rst      = 8'h01;
   localparam logic [7:0] comparator_input_select_rst = 8'h00;
   localparam logic [7:0] debounce_control_rst        = 8'h00;
   localparam logic [7:0] irq_mask_rst                = 8'h00;

   // Converter code full scale divisor.
   localparam int converter_full_scale = 64;

   // Low-speed RC clock divider: system cycles per low-speed tick.
   localparam int lirc_div_default = 8;

   // Input select encodings.
   typedef enum logic [1:0] {neg_pin_two, neg_pin_one, neg_converter} neg_source_t;
   typedef enum logic [1:0] {pos_amplifier, pos_pin_one, pos_pin_two} pos_source_t;
endpackage

/* testbench/comparator_debounce_ctrl_checker.sv */
// Port-level assertions for the comparator debounce control block.
`timescale 1ns/100ps
module comparator_debounce_ctrl_checker #(
   parameter int lirc_div = 8
) (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        comparator_raw,
   input wire logic        converter_enable,
   input wire logic [5:0]  converter_code,
   input wire logic        amplifier_enable,
   input wire logic [3:0]  amplifier_gain_select,
   input wire logic [1:0]  hysteresis_select,
   input wire logic        comparator_enable,
   input wire logic [1:0]  negative_input_select,
   input wire logic [1:0]  positive_input_select,
   input wire logic        pin_one_pullup_disable,
   input wire logic        pin_two_pullup_disable,
   input wire logic        comparator_edge_event,
   input wire logic        debounced_edge_event,
   input wire logic        irq
);
   logic       wr_ph; // High during the data phase of a write.
   logic [7:0] wr_a;  // Byte address of that write.
   ////////////////////////////////////////////////////////////////////////////////////////////
   // Tracks write data phases so field updates can be tied to the written data.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ph <= 1'b0;
         wr_a  <= 8'h00;
      end else begin
         wr_ph <= hsel && htrans[1] && hwrite && hready;
         wr_a  <= haddr[7:0];
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////////////////////////////////
   idle_rdata_a: assert property (!$past(hsel && htrans[1] && !hwrite && hready) |-> hrdata == 0)
      else $error("read data not zero outside a read data phase");
   upper_zero_a: assert property (hrdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   conv_write_a: assert property (wr_ph && wr_a == 8'h00 |=> converter_enable == $past(hwdata[7])
      && converter_code == $past(hwdata[5:0])) else $error("converter fields not written");
   amp_write_a: assert property (wr_ph && wr_a == 8'h04 |=> amplifier_enable == $past(hwdata[6]))
      else $error("amplifier enable not written");
   gain_write_a: assert property (wr_ph && wr_a == 8'h08 |=> amplifier_gain_select == $past(hwdata[3:0]))
      else $error("gain select not written");
   comp_write_a: assert property (wr_ph && wr_a == 8'h0c |=> hysteresis_select == $past(hwdata[5:4])
      && comparator_enable == $past(hwdata[0])) else $error("comparator fields not written");
   mux_write_a: assert property (wr_ph && wr_a == 8'h10 |=> negative_input_select == $past(hwdata[5:4])
      && positive_input_select == $past(hwdata[1:0])) else $error("input selects not written");
   pin_two_a: assert property (pin_two_pullup_disable == (negative_input_select == 2'b00
      || positive_input_select[1])) else $error("pin two pull-up control wrong");
   pin_one_a: assert property (pin_one_pullup_disable == (negative_input_select == 2'b01
      || positive_input_select == 2'b01)) else $error("pin one pull-up control wrong");
   edge_cause_a: assert property (comparator_edge_event |-> $past(comparator_raw, 2)
      && !$past(comparator_raw, 3) ##1 !comparator_edge_event) else $error("edge event without rise");
   deb_high_a: assert property (debounced_edge_event |-> $past(comparator_raw, 2)
      ##1 !debounced_edge_event) else $error("debounced event while input low");
   edge_seen_c: cover property (comparator_edge_event);
   deb_seen_c: cover property (debounced_edge_event);
   irq_seen_c: cover property (irq);
endmodule

/* testbench/tb_comparator_debounce_ctrl.sv */
// Self-checking bench for the comparator debounce control block.
`timescale 1ns/100ps
module tb_comparator_debounce_ctrl;
   logic        hclk, hresetn, hsel, hwrite, comparator_raw, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, d, seed;
   logic [1:0]  htrans, converter_clock_select, hysteresis_select;
   logic [1:0]  negative_input_select, positive_input_select;
   logic        converter_enable, amplifier_enable, comparator_enable, irq, rd_ph;
   logic        pin_one_pullup_disable, pin_two_pullup_disable;
   logic        comparator_edge_event, debounced_edge_event;
   logic [5:0]  converter_code;
   logic [3:0]  amplifier_gain_select;
   logic [7:0]  rstv [6] = '{8'h00, 8'h40, 8'h0f, 8'h01, 8'h00, 8'h00}; // Reset values.
   logic [7:0]  msk [6] = '{8'hbf, 8'h43, 8'h0f, 8'h31, 8'h33, 8'h07};  // Writable bits.
   logic [7:0]  wv [6];          // Last value written to each register.
   logic [31:0] q [$];           // Expected read data, oldest first.
   int          err_count, n_checks, ecnt, dcnt, ee, de, n;
   comparator_debounce_ctrl #(.lirc_div(2)) comparator_debounce_ctrl_inst (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .comparator_raw, .converter_enable,
      .converter_code, .converter_clock_select, .amplifier_enable, .amplifier_gain_select,
      .hysteresis_select, .comparator_enable, .negative_input_select, .positive_input_select,
      .pin_one_pullup_disable, .pin_two_pullup_disable, .comparator_edge_event,
      .debounced_edge_event, .irq);
   // Free-running 250 MHz clock.
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      if (err_count == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Bounded wait for hready high at a rising edge; a hang ends the run.
   task automatic wait_ready();
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 64);
      if (hreadyout !== 1'b1) begin
         err_count++;
         give_verdict();
      end
   endtask
   // One single AHB-Lite word transfer: address phase, then data phase.
   task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] v);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wr ? v : 32'h0;
      wait_ready();
   endtask
   // Notes the expected data, then reads.
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      q.push_back(e);
      bus(a, 1'b0, 32'h0);
   endtask
   // Holds the comparator high for a number of cycles, then lets events settle.
   task automatic pulse(input int hold);
      comparator_raw <= 1'b1;
      repeat (hold) @(posedge hclk);
      comparator_raw <= 1'b0;
      repeat (12) @(posedge hclk);
   endtask
   // Expected control outputs from the first five register values.
   function automatic logic [31:0] outs(input logic [7:0] w [6]);
      return {11'h0, w[0][7], w[0][5:0], w[1][6], w[1][1:0], w[2][3:0], w[3][5:4], w[3][0],
              w[4][5:4], w[4][1:0]};
   endfunction
   ////////////////////////////////////////////////////////////////////////////////////////////
   // Watcher: compares read data in each read data phase and counts event pulses.
   always @(posedge hclk) begin
      if (rd_ph === 1'b1) check("hrdata", hrdata, q.pop_front());
      rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
      if (comparator_edge_event === 1'b1) ecnt++;
      if (debounced_edge_event === 1'b1) dcnt++;
   end
   ////////////////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      {hresetn, hsel, hwrite, comparator_raw, rd_ph} = '0;
      {haddr, hwdata, htrans, err_count, n_checks, ecnt, dcnt, ee, de} = '0;
      seed = 32'h58d46843;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 6; i++) rd(8'(i * 4), {24'h0, rstv[i]});
      check("outputs", {11'h0, converter_enable, converter_code, amplifier_enable,
         converter_clock_select, amplifier_gain_select, hysteresis_select, comparator_enable,
         negative_input_select, positive_input_select}, outs(rstv));
      check("hresp", {31'h0, hresp}, 32'h0);
      for (int i = 0; i < 6; i++) begin
         d = $random(seed);
         if (i == 1) d[1:0] = 2'b00;
         if (i == 3) d[0] = 1'b1;
         wv[i] = d[7:0] & msk[i];
         bus(8'(i * 4), 1'b1, d);
         rd(8'(i * 4), {24'h0, wv[i]});
      end
      check("outputs", {11'h0, converter_enable, converter_code, amplifier_enable,
         converter_clock_select, amplifier_gain_select, hysteresis_select, comparator_enable,
         negative_input_select, positive_input_select}, outs(wv));
      bus(8'h24, 1'b1, 32'hff);
      rd(8'h24, 32'h0);
      // every debounce code; each nonzero code short and long
      bus(8'h1c, 1'b1, 32'h0);
      bus(8'h14, 1'b1, 32'h0);
      pulse(4);
      for (int s = 1; s < 8; s++) begin
         bus(8'h14, 1'b1, 32'(s));
         n = (s == 7) ? 128 : 4 << (s - 1);
         pulse(n);
         pulse(2 * n + 12);
      end
      check("edge count", 32'(ecnt), 32'd15);
      check("debounced count", 32'(dcnt), 32'd8);
      comparator_raw <= 1'b1;
      rd(8'h0c, {24'h0, 8'h80 | wv[3]});
      pulse(1);
      check("irq masked", {31'h0, irq}, 32'h0);
      rd(8'h18, 32'h3);
      rd(8'h18, 32'h0);
      bus(8'h1c, 1'b1, 32'h1);
      pulse(4);
      check("irq", {31'h0, irq}, 32'h1);
      rd(8'h18, 32'h1);
      repeat (3) @(posedge hclk);
      check("irq cleared", {31'h0, irq}, 32'h0);
      give_verdict();
   end
endmodule
bind comparator_debounce_ctrl comparator_debounce_ctrl_checker #(.lirc_div(lirc_div)) chk_inst (
   .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .comparator_raw,
   .converter_enable, .converter_code, .amplifier_enable, .amplifier_gain_select,
   .hysteresis_select, .comparator_enable, .negative_input_select, .positive_input_select,
   .pin_one_pullup_disable, .pin_two_pullup_disable, .comparator_edge_event,
   .debounced_edge_event, .irq);
